/* File: src/vcsd_params.svh */
// Constants for the video clock select and divide block
`ifndef VCSD_PARAMS_SVH
`define VCSD_PARAMS_SVH

// Register select codes on the four-bit register select port
`define VCSD_RS_SOURCE_SELECT   4'h9
`define VCSD_RS_OUTPUT_DIVIDE   4'hA

// Source select codes, bits 3..0
`define VCSD_SRC_ZERO           4'h0
`define VCSD_SRC_ONE            4'h1
`define VCSD_SRC_TWO            4'h2
`define VCSD_SRC_PAIR_TTL_A     4'h3
`define VCSD_SRC_PAIR_TTL_B     4'h4
`define VCSD_SRC_PAIR_ECL       4'h8

// Output divide register fields
`define VCSD_VID_MSB            5
`define VCSD_VID_LSB            3
`define VCSD_SHF_MSB            2
`define VCSD_SHF_LSB            0
`define VCSD_HOLD_CODE_MSBS     2'h3
`define VCSD_MAX_DIV_CODE       3'h5
`define VCSD_CNT_RESET_MASK     8'h36

// Reset values
`define VCSD_SOURCE_RESET       8'h00
`define VCSD_OUTPUT_RESET       8'h36

// Settling interval after a clock selection change
`define VCSD_SETTLE_NS          30
`define VCSD_CLK_NS             20
`define VCSD_SETTLE_CYC \
    ((`VCSD_SETTLE_NS + `VCSD_CLK_NS - 1) / `VCSD_CLK_NS)

`endif

/* File: src/vcsd_pkg.sv */
// Types shared by the video clock select and divide block
package vcsd_pkg;

    typedef enum logic [2:0] {
        VCSD_SEL_ZERO,
        VCSD_SEL_ONE,
        VCSD_SEL_TWO,
        VCSD_SEL_PAIR_A,
        VCSD_SEL_PAIR_B,
        VCSD_SEL_PAIR_ECL
    } vcsd_source_e;

    typedef struct packed {
        logic       ecl_mode;
        logic [5:0] clk_in;
    } vcsd_clk_in_s;

    typedef struct packed {
        logic [3:0] sel;
        logic       wr_n;
        logic       rd_n;
        logic [7:0] wdata;
    } vcsd_mpu_s;

endpackage

/* File: src/vcsd_sync_edge.sv */
// Two-flop synchroniser with a falling-edge pulse behind it
`timescale 1ns/100ps
`default_nettype none

module vcsd_sync_edge #(
    parameter int WIDTH = 1
) (
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out,
    output logic      [WIDTH-1:0] fall_pulse
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] last_r;

    generate
        for (genvar i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    meta_r[i]   <= 1'b1;
                    sync_out[i] <= 1'b1;
                    last_r[i]   <= 1'b1;
                end else begin
                    meta_r[i]   <= async_in[i];
                    sync_out[i] <= meta_r[i];
                    last_r[i]   <= sync_out[i];
                end
            end
            assign fall_pulse[i] = last_r[i] & ~sync_out[i];
        end
    endgenerate

endmodule

`default_nettype wire

/* File: src/vcsd_top.sv */
// Clock source selection and shift/video clock divider of a palette device
//
// Notes on behaviour
// - Up to five clock inputs: three TTL only, plus a pair that is either one ECL input or two TTL inputs.
// - The dual pair is ECL by default and turns TTL only when the source register selects one of its pins as TTL.
// - After reset clock input zero is the source.
// - Software may switch the source at any time by writing the source register.
// - The selected input is passed undivided as the pixel rate clock.
// - Source codes 0,1,2 select inputs zero to two, 3 and 4 a pair pin as TTL, 8 the pair as ECL; bits 7..4 are ignored.
// - Output bits 5..3 divide the video clock by 1 to 32 for codes 0 to 5; codes 11x hold it high.
// - Output bits 2..0 divide the shift clock by 1 to 32 for codes 0 to 5; codes 11x hold it low.
// - Bits 7 and 6 of the output register are ignored.
// - The output register value is the video code above the shift code, e.g. 0A or 2D.
// - After any selection change the divider counter stalls at least 30 ns before the divided clocks run; the pixel clock and divide by 1 are not held.
// - At reset the video clock is held high and the shift clock low.
// - Both divided output clocks come from one counter stepped on each pixel clock rising edge; divide by 1 follows the pixel clock.
// - The counter is held at zero while output bits 5, 4, 2 and 1 are all one.
// - Every reset loads the counter-reset pattern into the output register.
`timescale 1ns/100ps
`default_nettype none
`include "vcsd_params.svh"

module vcsd_top #(
    parameter int CNT_WIDTH = 5
) (
    input  wire logic                  mclk,
    input  wire logic                  sys_rst,
    input  wire logic                  soft_rst,
    input  wire vcsd_pkg::vcsd_mpu_s   mpu,
    input  wire vcsd_pkg::vcsd_clk_in_s clk_pins,
    output logic [7:0]                 rdata,
    output logic                       rdata_oe,
    output logic                       pixel_rate_clock,
    output logic                       video_clock_out,
    output logic                       shift_clock_out,
    output logic                       clocks_stable,
    output logic                       pair_ecl_enable
);
    import vcsd_pkg::*;

    // Elaboration-time refusal of counter widths the taps cannot serve
    if (CNT_WIDTH < 5 || CNT_WIDTH > 8) begin : g_bad_width
        $error("CNT_WIDTH must be 5 to 8");
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    localparam int NSYNC = 6 + 2 + 4;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] syn;
    logic [NSYNC-1:0] fall;
    logic [5:0]       clk_s;
    logic             wr_fall;
    logic             rd_s;
    logic [3:0]       sel_s;

    assign raw_in = {clk_pins.clk_in, mpu.wr_n, mpu.rd_n, mpu.sel};

    vcsd_sync_edge #(
        .WIDTH      (NSYNC)
    ) u_sync (
        .mclk       (mclk),
        .sys_rst    (sys_rst),
        .async_in   (raw_in),
        .sync_out   (syn),
        .fall_pulse (fall)
    );

    assign clk_s   = syn[NSYNC-1 -: 6];
    assign wr_fall = fall[5];
    assign rd_s    = ~syn[4];
    assign sel_s   = syn[3:0];

    // Write data is held stable by the host around the strobe
    logic [7:0] wdata_r;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wdata_r <= 8'h00;
        end else begin
            wdata_r <= mpu.wdata;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] source_r;
    logic [7:0] outdiv_r;
    logic       wr_src;
    logic       wr_out;

    assign wr_src = wr_fall && sel_s == `VCSD_RS_SOURCE_SELECT;
    assign wr_out = wr_fall && sel_s == `VCSD_RS_OUTPUT_DIVIDE;

    always_ff @(posedge mclk) begin
        if (sys_rst || soft_rst) begin
            source_r <= `VCSD_SOURCE_RESET;
        end else if (wr_src) begin
            source_r <= wdata_r;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst || soft_rst) begin
            outdiv_r <= `VCSD_OUTPUT_RESET;
        end else if (wr_out) begin
            outdiv_r <= wdata_r;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdata    <= 8'h00;
            rdata_oe <= 1'b0;
        end else begin
            rdata_oe <= rd_s && (sel_s == `VCSD_RS_SOURCE_SELECT ||
                                 sel_s == `VCSD_RS_OUTPUT_DIVIDE);
            rdata    <= (sel_s == `VCSD_RS_SOURCE_SELECT) ? source_r :
                        (sel_s == `VCSD_RS_OUTPUT_DIVIDE) ? outdiv_r :
                        8'h00;
        end
    end

    // ------------------------------------------------------------
    // Source decode
    // ------------------------------------------------------------
    vcsd_source_e src;
    always_comb begin
        case (source_r[3:0])
            `VCSD_SRC_ZERO:       src = VCSD_SEL_ZERO;
            `VCSD_SRC_ONE:        src = VCSD_SEL_ONE;
            `VCSD_SRC_TWO:        src = VCSD_SEL_TWO;
            `VCSD_SRC_PAIR_TTL_A: src = VCSD_SEL_PAIR_A;
            `VCSD_SRC_PAIR_TTL_B: src = VCSD_SEL_PAIR_B;
            `VCSD_SRC_PAIR_ECL:   src = VCSD_SEL_PAIR_ECL;
            default:              src = VCSD_SEL_ZERO;
        endcase
    end

    // ------------------------------------------------------------
    // Settling interval after any selection change
    // ------------------------------------------------------------
    localparam int SETTLE = (`VCSD_SETTLE_CYC < 1) ? 1 : `VCSD_SETTLE_CYC;
    logic [3:0] settle_r;
    always_ff @(posedge mclk) begin
        if (sys_rst || soft_rst || wr_src || wr_out) begin
            settle_r <= 4'(SETTLE);
        end else if (settle_r != 4'h0) begin
            settle_r <= settle_r - 4'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            clocks_stable <= 1'b0;
        end else begin
            clocks_stable <= (settle_r == 4'h0);
        end
    end

    // ------------------------------------------------------------
    // Pixel clock mux (sampled image of the chosen pin)
    // ------------------------------------------------------------
    logic pix_nxt;
    always_comb begin
        case (src)
            VCSD_SEL_ZERO:     pix_nxt = clk_s[0];
            VCSD_SEL_ONE:      pix_nxt = clk_s[1];
            VCSD_SEL_TWO:      pix_nxt = clk_s[2];
            VCSD_SEL_PAIR_A:   pix_nxt = clk_s[3];
            VCSD_SEL_PAIR_B:   pix_nxt = clk_s[4];
            VCSD_SEL_PAIR_ECL: pix_nxt = clk_s[3];
            default:           pix_nxt = clk_s[0];
        endcase
    end

    logic pix_r;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pix_r            <= 1'b0;
            pixel_rate_clock <= 1'b0;
            pair_ecl_enable  <= 1'b1;
        end else begin
            pix_r            <= pix_nxt;
            pixel_rate_clock <= pix_nxt;
            pair_ecl_enable  <= !(src == VCSD_SEL_PAIR_A ||
                                  src == VCSD_SEL_PAIR_B);
        end
    end

    logic pix_rise;
    assign pix_rise = pix_nxt & ~pix_r & (settle_r == 4'h0);

    // ------------------------------------------------------------
    // Shared divider counter
    // ------------------------------------------------------------
    logic [CNT_WIDTH-1:0] cnt_r;
    logic                 cnt_hold;
    assign cnt_hold = (outdiv_r & `VCSD_CNT_RESET_MASK) ==
                      `VCSD_CNT_RESET_MASK;

    always_ff @(posedge mclk) begin
        if (sys_rst || cnt_hold) begin
            cnt_r <= '0;
        end else if (pix_rise) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // Divide by 2^n: counter bit n-1; divide by 1 follows the pixel clock
    function automatic logic tap(input logic [2:0] code,
                                 input logic [CNT_WIDTH-1:0] c,
                                 input logic pix);
        logic r;
        r = pix;
        if (code != 3'h0 && code <= `VCSD_MAX_DIV_CODE) begin
            r = c[code - 3'h1];
        end
        return r;
    endfunction

    logic [2:0] vid_code;
    logic [2:0] shf_code;
    assign vid_code = outdiv_r[`VCSD_VID_MSB:`VCSD_VID_LSB];
    assign shf_code = outdiv_r[`VCSD_SHF_MSB:`VCSD_SHF_LSB];

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            video_clock_out <= 1'b1;
        end else if (vid_code[2:1] == `VCSD_HOLD_CODE_MSBS) begin
            video_clock_out <= 1'b1;
        end else begin
            video_clock_out <= tap(vid_code, cnt_r, pix_r);
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            shift_clock_out <= 1'b0;
        end else if (shf_code[2:1] == `VCSD_HOLD_CODE_MSBS) begin
            shift_clock_out <= 1'b0;
        end else begin
            shift_clock_out <= tap(shf_code, cnt_r, pix_r);
        end
    end

endmodule

`default_nettype wire

/* File: sim/vcsd_top_sva.sv */
// Checker for the clock select and divide block
`timescale 1ns/100ps
`default_nettype none
module vcsd_top_sva #(
    parameter int CNT_WIDTH = 5
) (
    input wire logic                   mclk,
    input wire logic                   sys_rst,
    input wire logic                   soft_rst,
    input wire vcsd_pkg::vcsd_mpu_s    mpu,
    input wire vcsd_pkg::vcsd_clk_in_s clk_pins,
    input wire logic [7:0]             rdata,
    input wire logic                   rdata_oe,
    input wire logic                   pixel_rate_clock,
    input wire logic                   video_clock_out,
    input wire logic                   shift_clock_out,
    input wire logic                   clocks_stable,
    input wire logic                   pair_ecl_enable
);
    import vcsd_pkg::*;
    logic [7:0] src_r;
    logic [7:0] out_r;
    logic [4:0] age_r;
    // Shadow registers, trusted only once a write has long settled
    wire        quiet   = (age_r == 5'h1F);
    wire        reg_sel = (mpu.sel == 4'h9) || (mpu.sel == 4'hA);
    wire  [2:0] pin_idx = (src_r[3:0] <= 4'h4) ? src_r[2:0] :
                          ((src_r[3:0] == 4'h8) ? 3'h3 : 3'h0);
    always_ff @(posedge mclk) begin
        if (sys_rst || soft_rst) begin
            src_r <= 8'h00;
            out_r <= 8'h36;
        end else if ($fell(mpu.wr_n) && mpu.sel == 4'h9) begin
            src_r <= mpu.wdata;
        end else if ($fell(mpu.wr_n) && mpu.sel == 4'hA) begin
            out_r <= mpu.wdata;
        end
    end
    always_ff @(posedge mclk) begin
        if (sys_rst || soft_rst || $fell(mpu.wr_n))
            age_r <= 5'h00;
        else if (!quiet)
            age_r <= age_r + 5'h01;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst || soft_rst);
    AST_RST_VALUES: assert property ($fell(sys_rst) |->
        video_clock_out && !shift_clock_out && pair_ecl_enable)
        else $error("reset output levels wrong");
    AST_VIDEO_HELD: assert property (
        quiet && out_r[5:4] == 2'h3 |-> video_clock_out)
        else $error("video clock not held high");
    AST_SHIFT_HELD: assert property (
        quiet && out_r[2:1] == 2'h3 |-> !shift_clock_out)
        else $error("shift clock not held low");
    AST_PIX_FOLLOW: assert property (
        quiet && $rose(clk_pins.clk_in[pin_idx]) |->
        ##[1:5] $rose(pixel_rate_clock))
        else $error("pixel clock does not follow selected pin");
    AST_PAIR_MODE: assert property (quiet |->
        pair_ecl_enable == !(src_r[3:0] inside {4'h3, 4'h4}))
        else $error("pair mode wrong");
    AST_IN_PHASE: assert property (
        quiet && out_r[5:3] == out_r[2:0] && out_r[2:0] <= 3'h5 &&
        $rose(shift_clock_out) |-> $rose(video_clock_out))
        else $error("video clock out of phase with shift clock");
    AST_SETTLE: assert property ($fell(clocks_stable) |=>
        !clocks_stable ##[1:3] clocks_stable)
        else $error("settle interval wrong");
    AST_READ_OE: assert property (($fell(mpu.rd_n) && reg_sel) ##1
        !mpu.rd_n [*4] |-> rdata_oe)
        else $error("read data not driven");
    AST_NO_OE: assert property ((mpu.rd_n || !reg_sel) [*5] |-> !rdata_oe)
        else $error("read data driven without a read");
    AST_READ_DATA: assert property (
        quiet && !mpu.rd_n && mpu.sel == 4'hA && rdata_oe |->
        rdata[5:0] == out_r[5:0])
        else $error("divide register read back wrong");
    COV_SHIFT32: cover property (quiet && out_r[2:0] == 3'h5 &&
        $rose(shift_clock_out));
    COV_SETTLE: cover property ($fell(clocks_stable));
    COV_ECL: cover property (quiet && src_r[3:0] == 4'h8);
endmodule
bind vcsd_top vcsd_top_sva #(.CNT_WIDTH(CNT_WIDTH)) u_sva (
    .mclk(mclk), .sys_rst(sys_rst), .soft_rst(soft_rst), .mpu(mpu),
    .clk_pins(clk_pins), .rdata(rdata), .rdata_oe(rdata_oe),
    .pixel_rate_clock(pixel_rate_clock), .video_clock_out(video_clock_out),
    .shift_clock_out(shift_clock_out), .clocks_stable(clocks_stable),
    .pair_ecl_enable(pair_ecl_enable));
`default_nettype wire

/* File: sim/vcsd_clk_partner.sv */
// Model of the external clock sources feeding the clock pins
`timescale 1ns/100ps
`default_nettype none
module vcsd_clk_partner (
    input  wire logic                  mclk,
    input  wire logic                  stop,
    input  wire logic                  ecl_en,
    output var vcsd_pkg::vcsd_clk_in_s pins
);
    import vcsd_pkg::*;
    logic [4:0] lvl  = 5'h00;
    int         tick [5] = '{0, 0, 0, 0, 0};
    logic       junk = 1'b0;
    // Pin k (0 to 4) toggles every 4+k cycles and freezes while stopped; pin 5 toggles every cycle
    always @(negedge mclk) begin
        junk <= ~junk;
        for (int k = 0; k < 5; k++) begin
            if (!stop && tick[k] == 3 + k) begin
                tick[k] <= 0;
                lvl[k] <= ~lvl[k];
            end else if (!stop) begin
                tick[k] <= tick[k] + 1;
            end
        end
    end
    // ECL pair is differential, otherwise two free TTL pins
    assign pins.clk_in   = {junk, ecl_en ? ~lvl[3] : lvl[4], lvl[3:0]};
    assign pins.ecl_mode = ecl_en;
endmodule
`default_nettype wire

/* File: sim/tb_vcsd_top.sv */
// Self-checking bench for the clock select and divide block
`timescale 1ns/100ps
`default_nettype none
module tb_vcsd_top;
    import vcsd_pkg::*;
    logic          mclk = 1'b0, sys_rst = 1'b1, soft_rst = 1'b0, stop = 1'b0;
    vcsd_mpu_s     mpu = '{4'h0, 1'b1, 1'b1, 8'h00};
    vcsd_clk_in_s  pins;
    logic [7:0]    rdata;
    logic          oe, pix, vid, shf, stable, ecl;
    int            mismatches = 0, checks = 0, cyc = 0;
    vcsd_top DUT (.mclk(mclk), .sys_rst(sys_rst), .soft_rst(soft_rst),
        .mpu(mpu), .clk_pins(pins), .rdata(rdata), .rdata_oe(oe),
        .pixel_rate_clock(pix), .video_clock_out(vid),
        .shift_clock_out(shf), .clocks_stable(stable),
        .pair_ecl_enable(ecl));
    vcsd_clk_partner u_far (.mclk(mclk), .stop(stop), .ecl_en(ecl),
        .pins(pins));
    initial forever #10 mclk = ~mclk;
    task automatic cmp(input string w, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic cmp_n(input string w, input int e, input int g);
        checks++;
        if (g != e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %0d seen %0d", w, e, g);
        end
    endtask
    function automatic logic sig(input int w);
        return (w == 0) ? pix : ((w == 1) ? shf : vid);
    endfunction
    // Cycles between two rising edges, -1 when none within the bound
    task automatic per(input int w, output int p);
        logic pv;
        int   n, t0;
        pv = sig(w);
        n = 0;
        t0 = -1;
        p = -1;
        while (n < 1200 && p < 0) begin
            @(negedge mclk);
            n++;
            if (sig(w) === 1'b1 && pv === 1'b0)
                if (t0 < 0) t0 = n;
                else p = n - t0;
            pv = sig(w);
        end
    endtask
    task automatic wr(input logic [3:0] s, input logic [7:0] d);
        @(negedge mclk);
        mpu.sel = s;
        mpu.wdata = d;
        @(negedge mclk);
        mpu.wr_n = 1'b0;
        repeat (4) @(negedge mclk);
        mpu.wr_n = 1'b1;
        repeat (12) @(negedge mclk);
    endtask
    task automatic rd(input logic [3:0] s, input logic [7:0] e,
                      input logic [7:0] m, input logic eoe);
        @(negedge mclk);
        mpu.sel = s;
        @(negedge mclk);
        mpu.rd_n = 1'b0;
        repeat (5) @(negedge mclk);
        cmp("read enable", {7'h00, eoe}, {7'h00, oe});
        if (eoe) cmp("read data", e & m, rdata & m);
        mpu.rd_n = 1'b1;
        repeat (4) @(negedge mclk);
    endtask
    task automatic t_reset;
        int p;
        cmp("video", 8'h01, {7'h00, vid});
        cmp("shift", 8'h00, {7'h00, shf});
        cmp("pair ecl", 8'h01, {7'h00, ecl});
        rd(4'h9, 8'h00, 8'hFF, 1'b1);
        rd(4'hA, 8'h36, 8'h3F, 1'b1);
        per(0, p);
        cmp_n("pixel period", 8, p);
    endtask
    task automatic t_source;
        logic [7:0] code [9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04,
                                 8'h08, 8'h05, 8'h0F, 8'hF2};
        int         pin [9] = '{0, 1, 2, 3, 4, 3, 0, 0, 2};
        int         p;
        for (int i = 0; i < 9; i++) begin
            wr(4'h9, code[i]);
            cmp("pair ecl", {7'h00, !(code[i][3:0] inside {4'h3, 4'h4})},
                {7'h00, ecl});
            per(0, p);
            cmp_n("pixel period", 2 * (4 + pin[i]), p);
            rd(4'h9, code[i], 8'h0F, 1'b1);
        end
        wr(4'h9, 8'h00);
    endtask
    task automatic t_outdiv;
        logic [7:0] v [10] = '{8'h05, 8'h0A, 8'h13, 8'h1C, 8'h21, 8'h28,
                               8'hED, 8'h31, 8'h0E, 8'h37};
        int         p;
        for (int i = 0; i < 10; i++) begin
            wr(4'hA, v[i]);
            rd(4'hA, v[i], 8'h3F, 1'b1);
            per(1, p);
            cmp_n("shift period", v[i][2:1] == 2'h3 ? -1 : 8 << v[i][2:0], p);
            if (v[i][2:1] == 2'h3) cmp("shift held", 8'h00, {7'h00, shf});
            per(2, p);
            cmp_n("video period", v[i][5:4] == 2'h3 ? -1 : 8 << v[i][5:3], p);
            if (v[i][5:4] == 2'h3) cmp("video held", 8'h01, {7'h00, vid});
        end
    endtask
    task automatic t_sync;
        int p;
        stop = 1'b1;
        wr(4'hA, 8'h36);
        wr(4'hA, 8'h12);
        stop = 1'b0;
        per(1, p);
        cmp_n("shift period", 32, p);
        per(2, p);
        cmp_n("video period", 32, p);
    endtask
    task automatic t_soft;
        wr(4'h9, 8'h02);
        wr(4'hA, 8'h0A);
        @(negedge mclk);
        soft_rst = 1'b1;
        @(negedge mclk);
        soft_rst = 1'b0;
        repeat (8) @(negedge mclk);
        cmp("video", 8'h01, {7'h00, vid});
        rd(4'h9, 8'h00, 8'hFF, 1'b1);
        wr(4'h0, 8'h2D);
        rd(4'hA, 8'h36, 8'h3F, 1'b1);
        rd(4'h0, 8'h00, 8'h00, 1'b0);
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 60000) begin
            mismatches++;
            print_verdict();
        end
    end
    initial begin
        repeat (4) @(negedge mclk);
        sys_rst = 1'b0;
        t_reset();
        t_source();
        t_outdiv();
        t_sync();
        t_soft();
        print_verdict();
    end
endmodule
`default_nettype wire
